// ==== sim/ncs_link_props.sv ====
// Checker on the link between both ends.
// Assumes tb instantiates it beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module ncs_link_props
	import ncs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [NCS_AW-1:0] regAddr,
	input wire logic [NCS_DW-1:0] regWdata,
	input wire logic regRvalid,
	input wire logic syncReqN,
	input wire logic sysref,
	input wire logic lineMode64,
	input wire logic phaseInit,
	input wire logic linkResync,
	input wire logic syncArmed
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Shadow of the link-request enable, since the checker cannot read it
	logic linkEn_q;
	always_ff @(posedge core_clk or posedge rst)
		if (rst) linkEn_q <= 1'b1;
		else if (regWrite && regAddr == NCS_ADDR_SYNC) linkEn_q <= regWdata[NCS_BIT_LINKREQ];
	sequence s_arm0;
		regWrite && regAddr == NCS_ADDR_SYNC && !regWdata[NCS_BIT_ARM];
	endsequence
	sequence s_arm1;
		regWrite && regAddr == NCS_ADDR_SYNC && regWdata[NCS_BIT_ARM];
	endsequence
	sequence s_init_disarmed;
		phaseInit && !syncArmed;
	endsequence
	a_arm_then_pulse: assert property (s_arm0 ##1 s_arm1 |=> sysref)
		else $error("no sysref");
	a_sysref_init: assert property ($rose(sysref) && syncArmed
		|-> ##[2:5] s_init_disarmed) else $error("sysref init missing");
	a_arm_needs_write: assert property ($rose(syncArmed)
		|-> $past(regWrite && regAddr == NCS_ADDR_SYNC)) else $error("armed without write");
	a_linkreq_init: assert property ($rose(syncReqN) && linkEn_q
		|-> ##[2:22] phaseInit) else $error("link request init missing");
	a_resync_8b10b: assert property ($rose(syncReqN) && !lineMode64
		|-> ##[2:5] linkResync) else $error("no resync in 8b10b");
	a_quiet_64b: assert property (lineMode64 && $past(lineMode64, 4)
		|-> !linkResync) else $error("resync in 64b66b");
	a_read_answer: assert property (regRead |=> regRvalid)
		else $error("read unanswered");
	a_no_stray_rvalid: assert property (regRvalid |-> $past(regRead))
		else $error("stray rvalid");
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench: controller end and converter end on one link.
// Assumes the package, interface and both ends compile first.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ncs_pkg::*;
	logic core_clk = 0, rst = 1, lineMode64 = 0, cmdWrite = 0, cmdRead = 0, cmdAlign = 0;
	logic linkSyncRequest = 0, devicesReady = 0, busy, refused, rdValid, phaseInit, linkResync;
	logic syncArmed;
	int reads = 0, n0;
	logic [11:0] cmdAddr = 0;
	logic [15:0] cmdData = 0, phaseOffset = 0, rdData;
	logic [31:0] freqWord = 0, ncoPhase, lastInit, prev;
	int fail_count = 0, cmp_count = 0, inits = 0, resyncs = 0, refusals = 0, cyc = 0, i0, r0;
	ncs_link_if link();
	ncs_device_end ncs_device_end_i(.core_clk(core_clk), .rst(rst), .link(link),
		.lineMode64(lineMode64), .freqWord(freqWord), .phaseOffset(phaseOffset),
		.ncoPhase(ncoPhase), .phaseInit(phaseInit), .linkResync(linkResync), .syncArmed(syncArmed));
	ncs_ctrl_end ncs_ctrl_end_i(.core_clk(core_clk), .rst(rst), .link(link), .cmdWrite(cmdWrite),
		.cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdAlign(cmdAlign),
		.linkSyncRequest(linkSyncRequest), .devicesReady(devicesReady), .busy(busy),
		.refused(refused), .rdData(rdData), .rdValid(rdValid));
	ncs_link_props ncs_link_props_i(.core_clk(core_clk), .rst(rst), .regWrite(link.regWrite),
		.regRead(link.regRead), .regAddr(link.regAddr), .regWdata(link.regWdata),
		.regRvalid(link.regRvalid), .syncReqN(link.syncReqN), .sysref(link.sysref),
		.lineMode64(lineMode64), .phaseInit(phaseInit), .linkResync(linkResync),
		.syncArmed(syncArmed));
	// ----------------------------------------
	// Clock, monitor and helpers
	// ----------------------------------------
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (phaseInit === 1'b1) begin
			inits++;
			lastInit = ncoPhase;
		end
		if (linkResync === 1'b1) resyncs++;
		if (refused === 1'b1) refusals++;
		if (rdValid === 1'b1) reads++;
		// Ceiling well above the few hundred cycles the tests need
		if (cyc > 5000) begin
			fail_count++;
			finish_test;
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cmd(input logic w, input logic [11:0] a, input logic [15:0] d);
		cmdWrite <= w;
		cmdRead <= !w;
		cmdAddr <= a;
		cmdData <= d;
		@(posedge core_clk);
		cmdWrite <= 0;
		cmdRead <= 0;
		repeat (4) @(posedge core_clk);
	endtask
	task rd(input logic [11:0] a, input logic [15:0] exp);
		n0 = reads;
		cmd(0, a, 16'h0000);
		check(32'(rdData), 32'(exp));
		check(32'(reads - n0), 32'h1);
	endtask
	task t_regs;
		rd(NCS_ADDR_RDIV, NCS_RDIV_RESET);
		rd(NCS_ADDR_SYNC, 16'h0002);
		rd(12'h218, 16'h0000);
		freqWord <= 32'h0003_0000;
		cmd(1, NCS_ADDR_RDIV, 16'h0004);
		rd(NCS_ADDR_RDIV, 16'h0004);
		repeat (12) begin
			@(posedge core_clk);
			check(32'(ncoPhase < 32'h0004_0000), 32'h1);
		end
		// The advised ceiling itself is still accepted
		cmd(1, NCS_ADDR_RDIV, 16'h2000);
		rd(NCS_ADDR_RDIV, 16'h2000);
		cmd(1, NCS_ADDR_RDIV, 16'h2001);
		check(32'(refusals), 32'h1);
		rd(NCS_ADDR_RDIV, 16'h2000);
		cmd(1, NCS_ADDR_RDIV, 16'h0000);
		repeat (6) begin
			prev = ncoPhase;
			@(posedge core_clk);
			check(ncoPhase - prev, 32'h0003_0000);
		end
		$display("test regs done");
	endtask
	task t_linkreq;
		phaseOffset <= 16'h1234;
		// A new word leaves the phase undetermined until the next sync
		freqWord <= 32'h0001_0000;
		// Pass 0: 8b10b, pass 1: 64b66b, pass 2: enable cleared
		for (int m = 0; m < 3; m++) begin
			lineMode64 <= (m == 1);
			if (m == 2) cmd(1, NCS_ADDR_SYNC, 16'h0000);
			i0 = inits;
			r0 = resyncs;
			linkSyncRequest <= 1;
			repeat (4) @(posedge core_clk);
			linkSyncRequest <= 0;
			repeat (26) @(posedge core_clk);
			check(32'(inits - i0), 32'(m < 2));
			check(32'(resyncs - r0), 32'(m != 1));
			check(lastInit, 32'h1234_0000);
		end
		$display("test linkreq done");
	endtask
	task t_align;
		r0 = refusals;
		phaseOffset <= 16'h5678;
		cmdAlign <= 1;
		@(posedge core_clk);
		cmdAlign <= 0;
		repeat (4) @(posedge core_clk);
		check(32'(refusals - r0), 32'h1);
		devicesReady <= 1;
		i0 = inits;
		cmdAlign <= 1;
		@(posedge core_clk);
		cmdAlign <= 0;
		@(posedge core_clk);
		check(32'(busy), 32'h1);
		repeat (15) @(posedge core_clk);
		check(32'(busy), 32'h0);
		check(32'(inits - i0), 32'h1);
		check(lastInit, 32'h5678_0000);
		check(32'(syncArmed), 32'h0);
		cmd(1, NCS_ADDR_SYNC, 16'h0001);
		check(32'(syncArmed), 32'h0);
		cmd(1, NCS_ADDR_SYNC, 16'h0000);
		cmd(1, NCS_ADDR_SYNC, 16'h0001);
		check(32'(syncArmed), 32'h1);
		check(32'(inits - i0), 32'h1);
		$display("test align done");
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 0;
		@(posedge core_clk);
		t_regs;
		t_linkreq;
		t_align;
		finish_test;
	end
endmodule
`default_nettype wire

// ==== src/ncs_ctrl_end.sv ====
// Controller end: register port master, SYNC~ and SYSREF source.
// Assumes the converter end shares core_clk and answers reads one cycle later.
`timescale 1ns/100ps
`default_nettype none
module ncs_ctrl_end
	import ncs_pkg::*;
#(
	parameter int SYSREF_HIGH = NCS_SYSREF_HIGH_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	ncs_link_if.ctl link,
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic [NCS_AW-1:0] cmdAddr,
	input wire logic [NCS_DW-1:0] cmdData,
	input wire logic cmdAlign,
	input wire logic linkSyncRequest,
	input wire logic devicesReady,
	output logic busy,
	output logic refused,
	output logic [NCS_DW-1:0] rdData,
	output logic rdValid
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CLEAR = 2'b01,
		ST_ARM = 2'b10,
		ST_PULSE = 2'b11
	} ncs_ctl_e;

	typedef struct packed {
		ncs_ctl_e st;
		logic wr;
		logic rd;
		logic [NCS_AW-1:0] addr;
		logic [NCS_DW-1:0] wdata;
		logic syncN;
		logic sref;
		logic [7:0] cnt;
		logic refused;
		logic [NCS_DW-1:0] rdata;
		logic rvalid;
	} ncs_ctl_s;

	ncs_ctl_s q;
	ncs_ctl_s d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.rd = 1'b0;
		d.refused = 1'b0;
		d.rvalid = link.regRvalid;
		if (link.regRvalid) begin
			d.rdata = link.regRdata;
		end
		d.syncN = ~linkSyncRequest;
		unique case (q.st)
			ST_IDLE: begin
				d.sref = 1'b0;
				if (cmdAlign) begin
					if (devicesReady) begin
						// Clearing the whole byte drops link-request enable and arm
						d.st = ST_CLEAR;
						d.wr = 1'b1;
						d.addr = NCS_ADDR_SYNC;
						d.wdata = {8'h00, NCS_SYNC_DISARMED};
					end else begin
						d.refused = 1'b1;
					end
				end else if (cmdWrite) begin
					// Large divisors cost spur performance, so they are kept out
					if (cmdAddr == NCS_ADDR_RDIV && cmdData > NCS_RDIV_ADVISED_MAX) begin
						d.refused = 1'b1;
					end else begin
						d.wr = 1'b1;
						d.addr = cmdAddr;
						d.wdata = cmdData;
					end
				end else if (cmdRead) begin
					d.rd = 1'b1;
					d.addr = cmdAddr;
				end
			end
			ST_CLEAR: begin
				d.st = ST_ARM;
				d.wr = 1'b1;
				d.wdata = {8'h00, NCS_SYNC_ARMED};
			end
			ST_ARM: begin
				d.st = ST_PULSE;
				d.sref = 1'b1;
				d.cnt = 8'(SYSREF_HIGH - 1);
			end
			ST_PULSE: begin
				if (q.cnt == 8'h00) begin
					d.sref = 1'b0;
					d.st = ST_IDLE;
				end else begin
					d.cnt = q.cnt - 8'h01;
				end
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.syncN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign link.regWrite = q.wr;
	assign link.regRead = q.rd;
	assign link.regAddr = q.addr;
	assign link.regWdata = q.wdata;
	assign link.syncReqN = q.syncN;
	assign link.sysref = q.sref;
	assign busy = (q.st != ST_IDLE);
	assign refused = q.refused;
	assign rdData = q.rdata;
	assign rdValid = q.rvalid;
endmodule
`default_nettype wire

// ==== src/ncs_device_end.sv ====
// Converter end: divisor and sync registers, phase accumulator, phase init.
// Assumes SYNC~ and SYSREF arrive as pins asynchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Divisor zero: plain 32-bit accumulator
// - Software programs only integer divisor values
// - Software keeps divisor at or below 8192
// - One divisor shared by all presets
// - Link-request enable: init at boundary after rise
// - Link-request init works in both codings
// - In 64B/66B, SYNC~ never touches link
// - Arm bit 0-then-1 arms SYSREF init
// - One SYSREF init, then disarmed
// - Controller prepares devices before arming
// - Controller clears enable, arms, pulses SYSREF
// - Software derives word from step and divisor
// - Phase offset left-justified, added to accumulator
// - Software resyncs after frequency change
module ncs_device_end
	import ncs_pkg::*;
#(
	parameter int LMFC_CYCLES = NCS_LMFC_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	ncs_link_if.dev link,
	input wire logic lineMode64,
	input wire logic [31:0] freqWord,
	input wire logic [15:0] phaseOffset,
	output logic [31:0] ncoPhase,
	output logic phaseInit,
	output logic linkResync,
	output logic syncArmed
);
	// ----------------------------------------
	// Parameters and state
	// ----------------------------------------
	localparam int LW = $clog2(LMFC_CYCLES + 1);
	localparam logic [LW-1:0] LMFC_LAST = LW'(LMFC_CYCLES - 1);

	typedef struct packed {
		logic [15:0] rdiv;
		logic [7:0] syncCtl;
		logic armZeroSeen;
		logic armed;
		logic [1:0] syncMeta;
		logic [1:0] srefMeta;
		logic syncPrev;
		logic srefPrev;
		logic linkPending;
		logic [LW-1:0] lmfcCnt;
		logic [31:0] acc;
		logic [31:0] phase;
		logic init;
		logic resync;
		logic [15:0] rdata;
		logic rvalid;
	} ncs_dev_s;

	ncs_dev_s q;
	ncs_dev_s d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic syncRise;
		logic srefRise;
		logic boundary;
		logic doInit;
		logic armWrite;
		logic [32:0] sum;
		logic [32:0] modulus;
		syncRise = 1'b0;
		srefRise = 1'b0;
		boundary = 1'b0;
		doInit = 1'b0;
		armWrite = 1'b0;
		sum = 33'h0;
		modulus = 33'h0;
		d = q;
		d.init = 1'b0;
		d.resync = 1'b0;
		d.rvalid = 1'b0;

		// ----------------------------------------
		// Pin synchronisers
		// ----------------------------------------
		// Two stages before anything looks at the pins
		d.syncMeta = {q.syncMeta[0], link.syncReqN};
		d.srefMeta = {q.srefMeta[0], link.sysref};
		d.syncPrev = q.syncMeta[1];
		d.srefPrev = q.srefMeta[1];
		syncRise = q.syncMeta[1] & ~q.syncPrev;
		srefRise = q.srefMeta[1] & ~q.srefPrev;

		// ----------------------------------------
		// Multiframe boundary
		// ----------------------------------------
		// Local multiframe / multiblock boundary
		boundary = (q.lmfcCnt == LMFC_LAST);
		d.lmfcCnt = boundary ? '0 : q.lmfcCnt + LW'(1);

		// ----------------------------------------
		// Register port
		// ----------------------------------------
		// Register writes
		if (link.regWrite) begin
			if (link.regAddr == NCS_ADDR_RDIV) begin
				d.rdiv = link.regWdata;
			end
			if (link.regAddr == NCS_ADDR_SYNC) begin
				d.syncCtl = link.regWdata[7:0];
				if (!link.regWdata[NCS_BIT_ARM]) begin
					d.armZeroSeen = 1'b1;
					d.armed = 1'b0;
				end else if (q.armZeroSeen) begin
					d.armed = 1'b1;
					armWrite = 1'b1;
					d.armZeroSeen = 1'b0;
				end
			end
		end

		// Register reads, answer one cycle later; unmapped reads zero
		if (link.regRead) begin
			d.rvalid = 1'b1;
			unique case (link.regAddr)
				NCS_ADDR_RDIV: d.rdata = q.rdiv;
				NCS_ADDR_SYNC: d.rdata = {8'h00, q.syncCtl};
				default: d.rdata = 16'h0000;
			endcase
		end

		// ----------------------------------------
		// Phase initialisation
		// ----------------------------------------
		// Edge is remembered until the next boundary; coding mode does not matter
		if (!q.syncCtl[NCS_BIT_LINKREQ]) begin
			d.linkPending = 1'b0;
		end else if (syncRise) begin
			d.linkPending = 1'b1;
		end
		if (q.linkPending && boundary && q.syncCtl[NCS_BIT_LINKREQ]) begin
			doInit = 1'b1;
			d.linkPending = syncRise;
		end

		// SYSREF init fires once, then disarms until re-armed
		// A re-arming write in the same cycle wins over the disarm
		if (q.armed && srefRise) begin
			doInit = 1'b1;
			if (!armWrite) begin
				d.armed = 1'b0;
			end
		end

		// Only 8B/10B lets SYNC~ request link resynchronisation
		d.resync = syncRise & ~lineMode64;

		// ----------------------------------------
		// Accumulator
		// ----------------------------------------
		// One divisor serves every preset
		// One subtraction per cycle, so freqWord must stay below the modulus
		sum = {1'b0, q.acc} + {1'b0, freqWord};
		modulus = {1'b0, q.rdiv, 16'h0000};
		if (q.rdiv == 16'h0000) begin
			d.acc = sum[31:0];
		end else if (sum >= modulus) begin
			d.acc = 32'(sum - modulus);
		end else begin
			d.acc = sum[31:0];
		end
		if (doInit) begin
			d.acc = 32'h0000_0000;
		end
		d.init = doInit;
		d.phase = d.acc + {phaseOffset, 16'h0000};
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.rdiv <= NCS_RDIV_RESET;
			q.syncCtl <= NCS_SYNC_RESET;
			// SYNC~ idles high, so start there to avoid a false rise after reset
			q.syncMeta <= 2'b11;
			q.syncPrev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.regRdata = q.rdata;
	assign link.regRvalid = q.rvalid;
	assign ncoPhase = q.phase;
	assign phaseInit = q.init;
	assign linkResync = q.resync;
	assign syncArmed = q.armed;
endmodule
`default_nettype wire

// ==== src/ncs_link_if.sv ====
// Link between the converter end and its controller end.
// Assumes both ends run on the same core_clk.
`timescale 1ns/100ps
`default_nettype none
interface ncs_link_if;
	import ncs_pkg::*;
	logic regWrite;
	logic regRead;
	logic [NCS_AW-1:0] regAddr;
	logic [NCS_DW-1:0] regWdata;
	logic [NCS_DW-1:0] regRdata;
	logic regRvalid;
	logic syncReqN;
	logic sysref;
	modport dev (
		input regWrite, regRead, regAddr, regWdata, syncReqN, sysref,
		output regRdata, regRvalid
	);
	modport ctl (
		output regWrite, regRead, regAddr, regWdata, syncReqN, sysref,
		input regRdata, regRvalid
	);
endinterface
`default_nettype wire

// ==== src/ncs_pkg.sv ====
// Shared constants for the NCO divisor and phase-sync block.
// Assumes both ends and the link interface import this package.
package ncs_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int NCS_AW = 12;
	localparam int NCS_DW = 16;
	localparam logic [11:0] NCS_ADDR_RDIV = 12'h217;
	localparam logic [11:0] NCS_ADDR_SYNC = 12'h219;
	localparam logic [15:0] NCS_RDIV_RESET = 16'h0000;
	localparam logic [7:0] NCS_SYNC_RESET = 8'h02;
	localparam int NCS_BIT_ARM = 0;
	localparam int NCS_BIT_LINKREQ = 1;
	localparam logic [15:0] NCS_RDIV_ADVISED_MAX = 16'h2000;
	localparam logic [7:0] NCS_SYNC_DISARMED = 8'h00;
	localparam logic [7:0] NCS_SYNC_ARMED = 8'h01;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int NCS_CLK_PERIOD_NS = 20;
	localparam int NCS_SYSREF_HIGH_NS = 100;
	localparam int NCS_SYSREF_HIGH_CYC =
		(NCS_SYSREF_HIGH_NS + NCS_CLK_PERIOD_NS - 1) / NCS_CLK_PERIOD_NS;
	localparam int NCS_LMFC_CYCLES = 16;
endpackage
